// File: inc/gpt_pkg.sv
// Constants, register map and types for the general-purpose timer block
package gpt_pkg;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CFG   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TIMER_A_MODE_FIELD  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TBMR  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CTL   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IMR   = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RIS   = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_MIS   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ICR   = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_TAILR = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_TBILR = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_TAMAT = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_TBMAT = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_TAPR  = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_TBPR  = 8'h3c;
	localparam logic [ADDR_W-1:0] OFS_TAR   = 8'h48;
	localparam logic [ADDR_W-1:0] OFS_TBR   = 8'h4c;

	// ****************************************
	// Field values and bit positions
	// ****************************************
	localparam logic [2:0] CFG_TIMER32 = 3'h0;
	localparam logic [2:0] CFG_RTC32   = 3'h1;
	localparam logic [2:0] CFG_SPLIT16 = 3'h4;
	localparam logic [1:0] MODE_ONESHOT  = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam int CTL_TA_EN    = 0;
	localparam int CTL_TA_STALL = 1;
	localparam int CTL_RTC_EN   = 4;
	localparam int CTL_TA_OTE   = 5;
	localparam int CTL_TB_EN    = 8;
	localparam int CTL_TB_STALL = 9;
	localparam int CTL_TB_OTE   = 13;
	localparam int RIS_TA_TO = 0;
	localparam int RIS_RTC   = 3;
	localparam int RIS_TB_TO = 8;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [15:0] CNT_RST   = 16'hffff;
	localparam logic [15:0] ILR_RST   = 16'hffff;
	localparam logic [15:0] MATCH_RST = 16'hffff;
	localparam logic [7:0]  PR_RST    = 8'h00;
	localparam logic [15:0] CTL_RST   = 16'h0000;
	localparam logic [31:0] RTC_START = 32'h0000_0001;
	localparam int RTC_IN_HZ   = 32768;
	localparam int RTC_TICK_HZ = 1;
	localparam int RTC_DIV     = RTC_IN_HZ / RTC_TICK_HZ;

	// Operating configuration, one-hot
	typedef enum logic [2:0] {
		GPT_OP_TIMER32 = 3'b001,
		GPT_OP_RTC     = 3'b010,
		GPT_OP_SPLIT   = 3'b100
	} gpt_op_type;

endpackage

// File: rtl/gpt_timer.sv
// General-purpose timer pair: 32-bit one-shot/periodic, 32-bit clock and split 16-bit timers
// Summary of operation
// - Two 16-bit counters, split or joined 32-bit
// - Trigger ORed with trigger chain from other blocks
// - Selector 0 timer32, 1 clock mode
// - Joined pair acts as one 32-bit timer or clock
// - Reset: inactive, counters and loads 0xffff
// - Reset: prescalers and prescale counters zero
// - Load write in 32-bit fills both halves
// - Count read in 32-bit returns both halves
// - Enable starts down count; A mode selects
// - At zero reload; one-shot stops, clears enable
// - Time-out sets raw bit until cleared
// - Unmasked time-out sets masked bit
// - Trigger only when output trigger enabled
// - Load write while running reloads next cycle
// - Stall enable freezes counter during debug stall
// - Clock mode counts up, starts at one
// - Divide pin clock to 1 Hz tick
// - Count equal match rolls to zero
// - Match sets raw bit; unmasked, also masked bit, interrupt
// - Clock enable overrides both stall enables
// - Selector 4 splits into two 16-bit timers
`timescale 1ns/1ns
module gpt_timer
	import gpt_pkg::*;
#(
	parameter int RTC_DIV_P = RTC_DIV
)
(
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	input  wire logic              capture_pin_0,
	input  wire logic              debug_stall,
	input  wire logic              trigger_chain_in,
	output logic                   trigger_out,
	output logic                   irq
);

	// ****************************************
	// Declarations
	// ****************************************
	gpt_op_type  op_q;
	logic [2:0]  cfg_q;
	logic [1:0]  mode_q  [0:1];
	logic [15:0] ctl_q;
	logic [15:0] imr_q;
	logic [15:0] ris_q;
	logic [15:0] ris_d;
	logic [15:0] ris_set;
	logic [15:0] mis;
	logic [15:0] ilr_q   [0:1];
	logic [15:0] match_q [0:1];
	logic [7:0]  pr_q    [0:1];
	logic [7:0]  pcnt_q  [0:1];
	logic [15:0] cnt_q   [0:1];
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] cnt32;
	logic [31:0] cnt32_d;
	logic [31:0] ilr32;
	logic [31:0] match32;
	logic [31:0] div_q;
	logic        cap_q;
	logic        irq_q;
	logic        trig_q;
	logic        is32;
	logic        wr_cfg;
	logic        wr_ctl;
	logic        wr_icr;
	logic        wr_ilr  [0:1];
	logic        wr_mat  [0:1];
	logic        wr_pr   [0:1];
	logic        wr_mode [0:1];
	logic        stall   [0:1];
	logic        to16    [0:1];
	logic        run32;
	logic        to32;
	logic        rtc_enter;
	logic        rtc_rise;
	logic        rtc_tick;
	logic        rtc_step;
	logic        rtc_match;
	logic        ta_event;

	// ****************************************
	// Register write decode
	// ****************************************
	assign wr_cfg     = reg_wr && (reg_addr == OFS_CFG);
	assign wr_ctl     = reg_wr && (reg_addr == OFS_CTL);
	assign wr_icr     = reg_wr && (reg_addr == OFS_ICR);
	assign wr_mode[0] = reg_wr && (reg_addr == OFS_TIMER_A_MODE_FIELD);
	assign wr_mode[1] = reg_wr && (reg_addr == OFS_TBMR);
	assign wr_ilr[0]  = reg_wr && (reg_addr == OFS_TAILR);
	assign wr_ilr[1]  = reg_wr && (reg_addr == OFS_TBILR);
	assign wr_mat[0]  = reg_wr && (reg_addr == OFS_TAMAT);
	assign wr_mat[1]  = reg_wr && (reg_addr == OFS_TBMAT);
	assign wr_pr[0]   = reg_wr && (reg_addr == OFS_TAPR);
	assign wr_pr[1]   = reg_wr && (reg_addr == OFS_TBPR);

	// Joined views of the two halves
	assign is32    = (op_q != GPT_OP_SPLIT);
	assign cnt32   = {cnt_q[1], cnt_q[0]};
	assign ilr32   = {ilr_q[1], ilr_q[0]};
	assign match32 = {match_q[1], match_q[0]};

	// Debug stall per half, never while the clock enable is set
	assign stall[0] = ctl_q[CTL_TA_STALL] && debug_stall && !ctl_q[CTL_RTC_EN];
	assign stall[1] = ctl_q[CTL_TB_STALL] && debug_stall && !ctl_q[CTL_RTC_EN];

	// ****************************************
	// Configuration
	// ****************************************
	// Selector and its one-hot decode
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			cfg_q <= CFG_TIMER32;
			op_q  <= GPT_OP_TIMER32;
		end
		else if (wr_cfg)
		begin
			cfg_q <= reg_wdata[2:0];
			if (reg_wdata[2:0] == CFG_RTC32)
				op_q <= GPT_OP_RTC;
			else if (reg_wdata[2])
				op_q <= GPT_OP_SPLIT;
			else
				op_q <= GPT_OP_TIMER32;
		end
	end

	// Entering clock mode from another configuration
	assign rtc_enter = wr_cfg && (reg_wdata[2:0] == CFG_RTC32) && (op_q != GPT_OP_RTC);

	// Control register, enables cleared by hardware on one-shot expiry
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			ctl_q <= CTL_RST;
		else if (wr_ctl)
			ctl_q <= reg_wdata[15:0];
		else
		begin
			if ((to32 || to16[0]) && (mode_q[0] == MODE_ONESHOT))
				ctl_q[CTL_TA_EN] <= 1'b0;
			if (to16[1] && (mode_q[1] == MODE_ONESHOT))
				ctl_q[CTL_TB_EN] <= 1'b0;
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			imr_q <= 16'h0000;
		else if (reg_wr && (reg_addr == OFS_IMR))
			imr_q <= reg_wdata[15:0];
	end

	// ****************************************
	// Clock-mode tick divider
	// ****************************************
	assign rtc_rise = capture_pin_0 && !cap_q;
	assign rtc_tick = rtc_rise && (div_q == 32'(RTC_DIV_P - 1));

	// Counts rising edges of the 32.768 kHz pin input
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			cap_q <= 1'b0;
			div_q <= 32'h0000_0000;
		end
		else
		begin
			cap_q <= capture_pin_0;
			if (op_q != GPT_OP_RTC)
				div_q <= 32'h0000_0000;
			else if (rtc_tick)
				div_q <= 32'h0000_0000;
			else if (rtc_rise)
				div_q <= div_q + 32'h0000_0001;
		end
	end

	// ****************************************
	// Joined 32-bit counter
	// ****************************************
	assign run32     = (op_q == GPT_OP_TIMER32) && ctl_q[CTL_TA_EN] && !stall[0];
	assign to32      = run32 && (cnt32 == 32'h0000_0000);
	assign rtc_step  = (op_q == GPT_OP_RTC) && ctl_q[CTL_TA_EN] && rtc_tick
		&& !stall[0] && !stall[1];
	assign rtc_match = rtc_step && (cnt32 == match32);

	// Next joined count
	always_comb
	begin
		cnt32_d = cnt32;
		if (rtc_enter)
			cnt32_d = RTC_START;
		else if ((op_q == GPT_OP_TIMER32) && wr_ilr[0])
			cnt32_d = reg_wdata;
		else if (to32)
			cnt32_d = ilr32;
		else if (run32)
			cnt32_d = cnt32 - 32'h0000_0001;
		else if (rtc_match)
			cnt32_d = 32'h0000_0000;
		else if (rtc_step)
			cnt32_d = cnt32 + 32'h0000_0001;
	end

	// ****************************************
	// Per-half registers and 16-bit counters
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_half
			localparam int EN_BIT = (gi == 0) ? CTL_TA_EN : CTL_TB_EN;
			logic run16;
			logic step16;

			assign run16    = (op_q == GPT_OP_SPLIT) && ctl_q[EN_BIT] && !stall[gi];
			assign step16   = run16 && (pcnt_q[gi] == 8'h00);
			assign to16[gi] = step16 && (cnt_q[gi] == 16'h0000);

			// Mode field
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					mode_q[gi] <= 2'h0;
				else if (wr_mode[gi])
					mode_q[gi] <= reg_wdata[1:0];
			end

			// Interval load; a joined write to the A load fills both halves
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					ilr_q[gi] <= ILR_RST;
				else if ((gi == 1) && is32 && wr_ilr[0])
					ilr_q[gi] <= reg_wdata[31:16];
				else if (wr_ilr[gi])
					ilr_q[gi] <= reg_wdata[15:0];
			end

			// Match value, joined the same way as the load
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					match_q[gi] <= MATCH_RST;
				else if ((gi == 1) && is32 && wr_mat[0])
					match_q[gi] <= reg_wdata[31:16];
				else if (wr_mat[gi])
					match_q[gi] <= reg_wdata[15:0];
			end

			// Prescale value and its counter
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
				begin
					pr_q[gi]   <= PR_RST;
					pcnt_q[gi] <= PR_RST;
				end
				else
				begin
					if (wr_pr[gi])
						pr_q[gi] <= reg_wdata[7:0];
					if (wr_pr[gi])
						pcnt_q[gi] <= reg_wdata[7:0];
					else if (step16)
						pcnt_q[gi] <= pr_q[gi];
					else if (run16)
						pcnt_q[gi] <= pcnt_q[gi] - 8'h01;
				end
			end

			// Counter half: joined value in 32-bit modes, own count when split
			always_ff @(posedge ref_clk)
			begin
				if (!resetn)
					cnt_q[gi] <= CNT_RST;
				else if (is32 || rtc_enter)
					cnt_q[gi] <= cnt32_d[16*gi +: 16];
				else if (wr_ilr[gi])
					cnt_q[gi] <= reg_wdata[15:0];
				else if (to16[gi])
					cnt_q[gi] <= ilr_q[gi];
				else if (step16)
					cnt_q[gi] <= cnt_q[gi] - 16'h0001;
			end
		end
	endgenerate

	// ****************************************
	// Status, interrupt and trigger
	// ****************************************
	assign ta_event = to32 || to16[0];

	// Hardware events; a set in the clearing cycle wins
	always_comb
	begin
		ris_set = 16'h0000;
		ris_set[RIS_TA_TO] = ta_event;
		ris_set[RIS_TB_TO] = to16[1];
		ris_set[RIS_RTC]   = rtc_match;
		ris_d = ris_q;
		if (wr_icr)
			ris_d = ris_q & ~reg_wdata[15:0];
		ris_d = ris_d | ris_set;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			ris_q <= 16'h0000;
		else
			ris_q <= ris_d;
	end

	assign mis = ris_q & imr_q;

	// Interrupt and converter trigger flip-flops
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			irq_q  <= 1'b0;
			trig_q <= 1'b0;
		end
		else
		begin
			irq_q  <= |mis;
			trig_q <= (ta_event && ctl_q[CTL_TA_OTE]) || (to16[1] && ctl_q[CTL_TB_OTE]);
		end
	end

	assign irq         = irq_q;
	assign trigger_out = trig_q || trigger_chain_in;

	// ****************************************
	// Register read
	// ****************************************
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (reg_addr == OFS_CFG)
			rdata_d = {29'h0, cfg_q};
		else if (reg_addr == OFS_TIMER_A_MODE_FIELD)
			rdata_d = {30'h0, mode_q[0]};
		else if (reg_addr == OFS_TBMR)
			rdata_d = {30'h0, mode_q[1]};
		else if (reg_addr == OFS_CTL)
			rdata_d = {16'h0, ctl_q};
		else if (reg_addr == OFS_IMR)
			rdata_d = {16'h0, imr_q};
		else if (reg_addr == OFS_RIS)
			rdata_d = {16'h0, ris_q};
		else if (reg_addr == OFS_MIS)
			rdata_d = {16'h0, mis};
		else if (reg_addr == OFS_TAILR)
			rdata_d = is32 ? ilr32 : {16'h0, ilr_q[0]};
		else if (reg_addr == OFS_TBILR)
			rdata_d = {16'h0, ilr_q[1]};
		else if (reg_addr == OFS_TAMAT)
			rdata_d = is32 ? match32 : {16'h0, match_q[0]};
		else if (reg_addr == OFS_TBMAT)
			rdata_d = {16'h0, match_q[1]};
		else if (reg_addr == OFS_TAPR)
			rdata_d = {24'h0, pr_q[0]};
		else if (reg_addr == OFS_TBPR)
			rdata_d = {24'h0, pr_q[1]};
		else if (reg_addr == OFS_TAR)
			rdata_d = is32 ? cnt32 : {16'h0, cnt_q[0]};
		else if (reg_addr == OFS_TBR)
			rdata_d = {16'h0, cnt_q[1]};
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			rdata_q <= 32'h0000_0000;
		else if (reg_rd)
			rdata_q <= rdata_d;
		else
			rdata_q <= 32'h0000_0000;
	end

	assign reg_rdata = rdata_q;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_timeout;
		to32 && !wr_ilr[0] && !wr_cfg;
	endsequence

	sequence s_reloaded;
		cnt32 == ilr32;
	endsequence

	property p_rst_values;
		@(posedge ref_clk) !resetn |=> (cnt32 == 32'hffff_ffff) && (ilr32 == 32'hffff_ffff)
			&& (ctl_q == CTL_RST);
	endproperty
	a_rst_values: assert property (p_rst_values) else $error("reset values wrong");

	property p_rst_prescale;
		@(posedge ref_clk) !resetn |=> (pr_q[0] == 8'h00) && (pr_q[1] == 8'h00)
			&& (pcnt_q[0] == 8'h00) && (pcnt_q[1] == 8'h00);
	endproperty
	a_rst_prescale: assert property (p_rst_prescale) else $error("prescale not zero");

	property p_reload;
		@(posedge ref_clk) disable iff (!resetn) s_timeout |=> s_reloaded;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload after zero");

	property p_oneshot_stop;
		@(posedge ref_clk) disable iff (!resetn)
			s_timeout ##0 (mode_q[0] == MODE_ONESHOT) && !wr_ctl |=> !ctl_q[CTL_TA_EN];
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

	property p_timeout_raw;
		@(posedge ref_clk) disable iff (!resetn)
			to32 |=> ris_q[RIS_TA_TO] && (trig_q == $past(ctl_q[CTL_TA_OTE]));
	endproperty
	a_timeout_raw: assert property (p_timeout_raw) else $error("time-out status or trigger");

	property p_clear;
		@(posedge ref_clk) disable iff (!resetn)
			wr_icr && reg_wdata[RIS_TA_TO] && !ta_event |=> !ris_q[RIS_TA_TO];
	endproperty
	a_clear: assert property (p_clear) else $error("raw bit not cleared");

	property p_ilr_load;
		@(posedge ref_clk) disable iff (!resetn)
			wr_ilr[0] && (op_q == GPT_OP_TIMER32) && !wr_cfg |=> cnt32 == $past(reg_wdata);
	endproperty
	a_ilr_load: assert property (p_ilr_load) else $error("load write not taken");

	property p_stall;
		@(posedge ref_clk) disable iff (!resetn)
			(op_q == GPT_OP_TIMER32) && stall[0] && !reg_wr |=> cnt32 == $past(cnt32);
	endproperty
	a_stall: assert property (p_stall) else $error("counter moved in stall");

	property p_rtc_match;
		@(posedge ref_clk) disable iff (!resetn)
			rtc_match && !wr_cfg |=> (cnt32 == 32'h0000_0000) && ris_q[RIS_RTC]
			##1 (irq == imr_q[RIS_RTC]);
	endproperty
	a_rtc_match: assert property (p_rtc_match) else $error("clock match handling");

	property p_read_a32;
		@(posedge ref_clk) disable iff (!resetn)
			reg_rd && (reg_addr == OFS_TAR) && is32
			|=> reg_rdata == {$past(cnt_q[1]), $past(cnt_q[0])};
	endproperty
	a_read_a32: assert property (p_read_a32) else $error("joined count read");

endmodule

// File: verif/tb_gpt_timer.sv
// Self-checking testbench for the general-purpose timer pair
`timescale 1ns/1ns
module tb_gpt_timer
	import gpt_pkg::*;
;
	// ****************************************
	// Signals and design instance
	// ****************************************
	localparam int DIV = 4;
	logic              ref_clk;
	logic              resetn;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [31:0]       reg_rdata;
	logic              capture_pin_0;
	logic              debug_stall;
	logic              trigger_chain_in;
	logic              trigger_out;
	logic              irq;
	logic              rd_pend;
	logic [31:0]       exp_q[$];
	logic [31:0]       v;
	logic [31:0]       nv;
	logic [31:0]       cnt;
	int                num_errors;
	int                cmp_count;

	gpt_timer #(.RTC_DIV_P(DIV)) gpt_timer_i (
		.ref_clk          (ref_clk),
		.resetn           (resetn),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata),
		.capture_pin_0    (capture_pin_0),
		.debug_stall      (debug_stall),
		.trigger_chain_in (trigger_chain_in),
		.trigger_out      (trigger_out),
		.irq              (irq)
	);

	// Free-running 50 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Read monitor: the cycle after a taken read carries the data
	always @(posedge ref_clk)
		rd_pend <= reg_rd;

	always @(negedge ref_clk)
	begin
		if (rd_pend === 1'b1 && exp_q.size() > 0)
			chk(reg_rdata, exp_q.pop_front());
	end

	// Watchdog against a hung run
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		num_errors++;
		tally_and_finish();
	end

	// ****************************************
	// Bus and pin tasks
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Notes the expected word, then issues the read
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Samples irq and trigger where settled
	task automatic chk_out(input logic ei, input logic et);
		@(negedge ref_clk);
		chk({31'h0, irq}, {31'h0, ei});
		chk({31'h0, trigger_out}, {31'h0, et});
		@(posedge ref_clk);
	endtask

	// Counts trigger pulses over a window of w cycles
	task automatic count_trig(input int w, output logic [31:0] c);
		c = 0;
		repeat (w)
		begin
			@(negedge ref_clk);
			if (trigger_out === 1'b1)
				c++;
		end
		@(posedge ref_clk);
	endtask

	// Slow clock on the capture pin, one rising edge per six cycles
	task automatic pins(input int n);
		repeat (n)
		begin
			capture_pin_0 <= 1'b1;
			repeat (3) @(posedge ref_clk);
			capture_pin_0 <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		num_errors = 0;
		cmp_count = 0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		capture_pin_0 = 1'b0;
		debug_stall = 1'b0;
		trigger_chain_in = 1'b0;
		void'($urandom(61400));
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		// Reset defaults and an unmapped address
		rd(OFS_CFG, 32'h0000_0000);
		rd(OFS_CTL, 32'h0000_0000);
		rd(OFS_TAR, 32'hffff_ffff);
		rd(OFS_TAILR, 32'hffff_ffff);
		rd(OFS_TAPR, 32'h0000_0000);
		rd(OFS_TBPR, 32'h0000_0000);
		rd(OFS_RIS, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		chk_out(1'b0, 1'b0);
		// Joined load and count, then split halves
		v = $urandom;
		wr(OFS_TAILR, v);
		rd(OFS_TAILR, v);
		rd(OFS_TAR, v);
		wr(OFS_CFG, {29'h0, CFG_SPLIT16});
		rd(OFS_TBILR, {16'h0, v[31:16]});
		rd(OFS_TAILR, {16'h0, v[15:0]});
		wr(OFS_CFG, {29'h0, CFG_TIMER32});
		// Periodic: one trigger pulse per load+1 cycles, B mode ignored
		nv = 32'(4 + $urandom_range(15, 0));
		wr(OFS_TBMR, {30'h0, MODE_ONESHOT});
		wr(OFS_TIMER_A_MODE_FIELD, {30'h0, MODE_PERIODIC});
		wr(OFS_TAILR, nv);
		wr(OFS_CTL, 32'h0000_0021);
		count_trig(10 * (int'(nv) + 1), cnt);
		chk(cnt, 32'h0000_000a);
		wr(OFS_CTL, 32'h0000_0001);
		count_trig(3 * (int'(nv) + 1), cnt);
		chk(cnt, 32'h0000_0000);
		trigger_chain_in <= 1'b1;
		@(posedge ref_clk);
		chk_out(1'b0, 1'b1);
		trigger_chain_in <= 1'b0;
		rd(OFS_RIS, 32'h0000_0001);
		rd(OFS_MIS, 32'h0000_0000);
		// Clear register: zero keeps, one clears
		wr(OFS_CTL, 32'h0000_0000);
		wr(OFS_ICR, 32'h0000_0000);
		rd(OFS_RIS, 32'h0000_0001);
		wr(OFS_ICR, 32'h0000_0001);
		rd(OFS_RIS, 32'h0000_0000);
		// One-shot with the time-out unmasked
		wr(OFS_IMR, 32'h0000_0001);
		wr(OFS_TIMER_A_MODE_FIELD, {30'h0, MODE_ONESHOT});
		wr(OFS_TAILR, nv);
		wr(OFS_CTL, 32'h0000_0021);
		count_trig(3 * (int'(nv) + 1), cnt);
		chk(cnt, 32'h0000_0001);
		rd(OFS_CTL, 32'h0000_0020);
		rd(OFS_TAR, nv);
		rd(OFS_MIS, 32'h0000_0001);
		chk_out(1'b1, 1'b0);
		wr(OFS_ICR, 32'h0000_0001);
		chk_out(1'b0, 1'b0);
		// Debug stall freezes; a load write still lands
		wr(OFS_TIMER_A_MODE_FIELD, {30'h0, MODE_PERIODIC});
		wr(OFS_TAILR, 32'h0001_0000);
		debug_stall <= 1'b1;
		wr(OFS_CTL, 32'h0000_0003);
		wr(OFS_TAILR, 32'h0000_0100);
		rd(OFS_TAR, 32'h0000_0100);
		repeat (10) @(posedge ref_clk);
		rd(OFS_TAR, 32'h0000_0100);
		wr(OFS_CTL, 32'h0000_0000);
		// Clock mode: starts at one, counts up despite stall, rolls at match
		wr(OFS_CFG, {29'h0, CFG_RTC32});
		rd(OFS_TAR, RTC_START);
		wr(OFS_TAMAT, 32'h0000_0003);
		wr(OFS_IMR, 32'h0000_0008);
		wr(OFS_CTL, 32'h0000_0213);
		pins(DIV);
		rd(OFS_TAR, 32'h0000_0002);
		pins(DIV);
		rd(OFS_TAR, 32'h0000_0003);
		rd(OFS_RIS, 32'h0000_0000);
		pins(DIV);
		rd(OFS_TAR, 32'h0000_0000);
		rd(OFS_RIS, 32'h0000_0008);
		rd(OFS_MIS, 32'h0000_0008);
		chk_out(1'b1, 1'b0);
		wr(OFS_ICR, 32'h0000_0008);
		rd(OFS_RIS, 32'h0000_0000);
		chk_out(1'b0, 1'b0);
		pins(DIV);
		rd(OFS_TAR, 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		tally_and_finish();
	end
endmodule
